/* design/dcdc_converter_config_mode_regs.v */
// Converter configuration and mode registers with bypass switch control
// Function
// - Configuration bit 7 reads 0 while the bypass switch is open and 1 while it is closed.
// - The four-bit target voltage code selects 1.8 V up by 0.1 V to 3.1 V, then 3.3 V and 3.5 V.
// - Configuration bit 2 set to 1 disables the local oscillator, 0 enables it.
// - Switch size code 00 is minimum and 11 maximum; software must not write 01 or 10.
// - Mode bits 6:4 pick a peak current limit of 200 mA at 001 up to 600 mA at 101.
// - Mode bit 3 set to 1 enables forced bypass.
// - Mode bit 2 set to 1 enables automatic bypass.
// - Mode bit 7 reads 0 and software writes 0 to it.
// - Mode bit 1 reads 1 and software writes 1 to it.
// - Mode bit 0 turns the converter off at 0 and on at 1.
// - The bypass switch stays closed while forced bypass or the automatic condition holds.
// - Automatic bypass closes below about 0.4 V margin and reopens above about 0.5 V.
`timescale 1ns/100ps
`default_nettype none
`include "dcdc_regs_defs.vh"

module dcdc_converter_config_mode_regs (
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_sfr_page,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_rd,
  input wire i_margin_low,
  input wire i_margin_high,
  output reg [7:0] o_sfr_rdata,
  output reg o_converter_enable,
  output reg [3:0] o_target_voltage_select,
  output reg o_local_osc_disable,
  output reg [1:0] o_power_switch_size,
  output reg [2:0] o_peak_current_limit,
  output reg o_forced_switch_close,
  output reg o_automatic_switch_close,
  output reg o_switch_close
);

  // Stored fields of the configuration register
  reg [3:0] target_voltage_select_ff;
  reg osc_dis_ff;
  reg [1:0] sw_size_ff;
  // Stored fields of the mode register
  reg [2:0] ilim_ff;
  reg forced_ff;
  reg auto_ff;
  reg enable_ff;

  reg [3:0] nxt_target_voltage_select;
  reg nxt_osc_dis;
  reg [1:0] nxt_sw_size;
  reg [2:0] nxt_ilim;
  reg nxt_forced;
  reg nxt_auto;
  reg nxt_enable;
  reg nxt_switch;
  reg [7:0] nxt_rdata;
  reg [7:0] cfg_view;
  reg [7:0] mode_view;

  wire cfg_sel;
  wire mode_sel;
  wire auto_hold;

  assign cfg_sel = (i_sfr_page == `CFG_PAGE) && (i_sfr_addr == `CFG_ADDR);
  assign mode_sel = (i_sfr_page == `MODE_PAGE) && (i_sfr_addr == `MODE_ADDR);

  bypass_hysteresis u_hyst (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_auto_en(auto_ff),
    .i_margin_low(i_margin_low),
    .i_margin_high(i_margin_high),
    .o_hold_closed(auto_hold)
  );

  // Register writes; status bit 7 has no storage so writes cannot touch it
  always @* begin
    nxt_target_voltage_select = target_voltage_select_ff;
    nxt_osc_dis = osc_dis_ff;
    nxt_sw_size = sw_size_ff;
    nxt_ilim = ilim_ff;
    nxt_forced = forced_ff;
    nxt_auto = auto_ff;
    nxt_enable = enable_ff;
    if (i_sfr_wr && cfg_sel) begin
      nxt_target_voltage_select = i_sfr_wdata[`CFG_TARGET_VOLTAGE_SELECT_HI:`CFG_TARGET_VOLTAGE_SELECT_LO];
      nxt_osc_dis = i_sfr_wdata[`CFG_LOCAL_OSC_DISABLE_BIT];
      nxt_sw_size = i_sfr_wdata[`CFG_SWSIZE_HI:`CFG_SWSIZE_LO];
    end
    if (i_sfr_wr && mode_sel) begin
      nxt_ilim = i_sfr_wdata[`MODE_ILIM_HI:`MODE_ILIM_LO];
      nxt_forced = i_sfr_wdata[`MODE_FORCED_BIT];
      nxt_auto = i_sfr_wdata[`MODE_AUTO_BIT];
      nxt_enable = i_sfr_wdata[`MODE_ENABLE_BIT];
    end
  end

  // Switch closes on forced bypass or the latched automatic condition
  always @* begin
    nxt_switch = forced_ff | auto_hold;
  end

  // Read views; reserved bits read fixed values
  always @* begin
    cfg_view = 8'h00;
    cfg_view[`CFG_STATUS_BIT] = o_switch_close;
    cfg_view[`CFG_TARGET_VOLTAGE_SELECT_HI:`CFG_TARGET_VOLTAGE_SELECT_LO] = target_voltage_select_ff;
    cfg_view[`CFG_LOCAL_OSC_DISABLE_BIT] = osc_dis_ff;
    cfg_view[`CFG_SWSIZE_HI:`CFG_SWSIZE_LO] = sw_size_ff;
    mode_view = 8'h00;
    mode_view[`MODE_RSVD_HI_BIT] = `RSVD_HI_VALUE;
    mode_view[`MODE_ILIM_HI:`MODE_ILIM_LO] = ilim_ff;
    mode_view[`MODE_FORCED_BIT] = forced_ff;
    mode_view[`MODE_AUTO_BIT] = auto_ff;
    mode_view[`MODE_RSVD_LO_BIT] = `RSVD_LO_VALUE;
    mode_view[`MODE_ENABLE_BIT] = enable_ff;
    nxt_rdata = o_sfr_rdata;
    if (i_sfr_rd) begin
      if (cfg_sel) begin
        nxt_rdata = cfg_view;
      end else if (mode_sel) begin
        nxt_rdata = mode_view;
      end else begin
        nxt_rdata = `UNMAPPED_READ;
      end
    end
  end

  // Stored fields, switch drive and read data
  // Reset fields are the slices of config word 8'h0B and mode word 8'h50
  // Config: code 0001, oscillator on, largest switch
  // Mode: limit code 101, both bypass modes off, converter off
  // Reserved mode bits have no storage and are not reset here
  // Switch starts open until a bypass mode asks for it
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      target_voltage_select_ff <= 4'h1;
      osc_dis_ff <= 1'b0;
      sw_size_ff <= 2'h3;
      ilim_ff <= 3'h5;
      forced_ff <= 1'b0;
      auto_ff <= 1'b0;
      enable_ff <= 1'b0;
      o_switch_close <= 1'b0;
      o_sfr_rdata <= 8'h00;
    end else begin
      target_voltage_select_ff <= nxt_target_voltage_select;
      osc_dis_ff <= nxt_osc_dis;
      sw_size_ff <= nxt_sw_size;
      ilim_ff <= nxt_ilim;
      forced_ff <= nxt_forced;
      auto_ff <= nxt_auto;
      enable_ff <= nxt_enable;
      o_switch_close <= nxt_switch;
      o_sfr_rdata <= nxt_rdata;
    end
  end

  // Analog-facing controls, each a flop copy of the next stored value
  // Kept separate from the stored fields so every output is a flop
  // Reset values match the stored fields above
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_converter_enable <= 1'b0;
      o_target_voltage_select <= 4'h1;
      o_local_osc_disable <= 1'b0;
      o_power_switch_size <= 2'h3;
      o_peak_current_limit <= 3'h5;
      o_forced_switch_close <= 1'b0;
      o_automatic_switch_close <= 1'b0;
    end else begin
      o_converter_enable <= nxt_enable;
      o_target_voltage_select <= nxt_target_voltage_select;
      o_local_osc_disable <= nxt_osc_dis;
      o_power_switch_size <= nxt_sw_size;
      o_peak_current_limit <= nxt_ilim;
      o_forced_switch_close <= nxt_forced;
      o_automatic_switch_close <= nxt_auto;
    end
  end

endmodule

`default_nettype wire

/* common/dcdc_regs_defs.vh */
// Register offsets, pages, field positions and reset values of the converter registers
`ifndef DCDC_REGS_DEFS_VH
`define DCDC_REGS_DEFS_VH

`define CFG_ADDR 8'h96
`define CFG_PAGE 8'h00
`define MODE_ADDR 8'hB3
`define MODE_PAGE 8'h02

`define CFG_RESET 8'h0B
`define MODE_RESET 8'h50

`define CFG_STATUS_BIT 7
`define CFG_TARGET_VOLTAGE_SELECT_HI 6
`define CFG_TARGET_VOLTAGE_SELECT_LO 3
`define CFG_LOCAL_OSC_DISABLE_BIT 2
`define CFG_SWSIZE_HI 1
`define CFG_SWSIZE_LO 0

`define MODE_RSVD_HI_BIT 7
`define MODE_ILIM_HI 6
`define MODE_ILIM_LO 4
`define MODE_FORCED_BIT 3
`define MODE_AUTO_BIT 2
`define MODE_RSVD_LO_BIT 1
`define MODE_ENABLE_BIT 0

`define RSVD_HI_VALUE 1'h0
`define RSVD_LO_VALUE 1'h1
`define UNMAPPED_READ 8'h00

`endif

/* design/bypass_hysteresis.v */
// Automatic bypass hysteresis latch on the input-to-target margin comparators
`timescale 1ns/100ps
`default_nettype none

module bypass_hysteresis (
  input wire i_clk,
  input wire i_nrst,
  input wire i_auto_en,
  input wire i_margin_low,
  input wire i_margin_high,
  output reg o_hold_closed
);

  reg nxt_hold;

  // Close below about 0.4 V, reopen above about 0.5 V or when automatic bypass is off
  always @* begin
    nxt_hold = o_hold_closed;
    if (!i_auto_en) begin
      nxt_hold = 1'b0;
    end else if (i_margin_low) begin
      nxt_hold = 1'b1;
    end else if (i_margin_high) begin
      nxt_hold = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hold_closed <= 1'b0;
    end else begin
      o_hold_closed <= nxt_hold;
    end
  end

endmodule

`default_nettype wire

/* tb/dcdc_regs_asserts.sv */
// Checker of the converter register bank outputs
`timescale 1ns/100ps
`default_nettype none
module dcdc_regs_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_margin_low,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_converter_enable,
  input wire logic [3:0] o_target_voltage_select,
  input wire logic o_local_osc_disable,
  input wire logic [1:0] o_power_switch_size,
  input wire logic [2:0] o_peak_current_limit,
  input wire logic o_forced_switch_close,
  input wire logic o_automatic_switch_close,
  input wire logic o_switch_close
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire cw = i_sfr_wr && i_sfr_page == 8'h00 && i_sfr_addr == 8'h96;
  wire mw = i_sfr_wr && i_sfr_page == 8'h02 && i_sfr_addr == 8'hB3;
  wire cr = i_sfr_rd && i_sfr_page == 8'h00 && i_sfr_addr == 8'h96;
  wire mr = i_sfr_rd && i_sfr_page == 8'h02 && i_sfr_addr == 8'hB3;
  AST_CFG: assert property (cw |=> {o_target_voltage_select, o_local_osc_disable,
    o_power_switch_size} == $past(i_sfr_wdata[6:0])) else $error("config fields wrong");
  AST_EN: assert property (mw |=> o_converter_enable == $past(i_sfr_wdata[0]))
    else $error("enable wrong");
  AST_MODE: assert property (mw |=> {o_peak_current_limit, o_forced_switch_close,
    o_automatic_switch_close} == $past(i_sfr_wdata[6:2])) else $error("mode fields wrong");
  AST_RSVD: assert property (mr |=> o_sfr_rdata[7] == 1'h0 && o_sfr_rdata[1] == 1'h1)
    else $error("reserved bits wrong");
  AST_STATUS: assert property (cr |=> o_sfr_rdata[7] == $past(o_switch_close))
    else $error("status bit wrong");
  AST_FORCED: assert property (o_forced_switch_close |=> o_switch_close)
    else $error("forced bypass open");
  AST_AUTO: assert property (o_automatic_switch_close && i_margin_low && !mw |-> ##2 o_switch_close)
    else $error("auto bypass open");
  AST_OPEN: assert property ($fell(o_switch_close) |-> !$past(o_forced_switch_close))
    else $error("switch opened while forced");
endmodule
bind dcdc_converter_config_mode_regs dcdc_regs_chk dcdc_regs_chk_inst (.*);
`default_nettype wire

/* tb/tb_dcdc_converter_config_mode_regs.sv */
// Self-checking bench of the converter register bank
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_dcdc_converter_config_mode_regs;
  logic i_clk = 1'h0, i_nrst = 1'h0, i_sfr_wr = 1'h0, i_sfr_rd = 1'h0;
  logic i_margin_low = 1'h0, i_margin_high = 1'h0;
  logic [7:0] i_sfr_page = 8'h00, i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, w;
  logic [3:0] o_target_voltage_select;
  logic [2:0] o_peak_current_limit;
  logic [1:0] o_power_switch_size;
  logic o_converter_enable, o_local_osc_disable, o_forced_switch_close;
  logic o_automatic_switch_close, o_switch_close;
  int error_cnt = 0, n_checks = 0;
  // Mode rows keep bit 7 at 0, bit 1 at 1 and limit codes 001..101
  logic [8:0] rows [8] = '{9'h080, 9'h077, 9'h07B, 9'h06C, 9'h113, 9'h153, 9'h137, 9'h122};
  dcdc_converter_config_mode_regs dcdc_converter_config_mode_regs_inst (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sfr_page(i_sfr_page),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_rd(i_sfr_rd),
    .i_margin_low(i_margin_low),
    .i_margin_high(i_margin_high),
    .o_sfr_rdata(o_sfr_rdata),
    .o_converter_enable(o_converter_enable),
    .o_target_voltage_select(o_target_voltage_select),
    .o_local_osc_disable(o_local_osc_disable),
    .o_power_switch_size(o_power_switch_size),
    .o_peak_current_limit(o_peak_current_limit),
    .o_forced_switch_close(o_forced_switch_close),
    .o_automatic_switch_close(o_automatic_switch_close),
    .o_switch_close(o_switch_close)
  );
  initial forever #25 i_clk = ~i_clk;
  task automatic acc(input logic [7:0] p, a, d, input logic wr);
    @(negedge i_clk);
    {i_sfr_page, i_sfr_addr, i_sfr_wdata, i_sfr_wr, i_sfr_rd} = {p, a, d, wr, !wr};
    @(negedge i_clk);
    {i_sfr_wr, i_sfr_rd} = 2'h0;
  endtask
  task automatic rchk;
    i_nrst = 1'h0;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'h1;
    `CK("reset", 22'h02E800, {o_converter_enable, o_target_voltage_select, o_local_osc_disable,
      o_power_switch_size, o_peak_current_limit, o_forced_switch_close,
      o_automatic_switch_close, o_switch_close, o_sfr_rdata})
    acc(8'h00, 8'h96, 8'h00, 1'h0);
    `CK("cfg", 8'h0B, o_sfr_rdata)
    acc(8'h02, 8'hB3, 8'h00, 1'h0);
    `CK("mode", 8'h52, o_sfr_rdata)
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rchk();
    foreach (rows[i]) begin
      w = rows[i][7:0];
      if (rows[i][8]) begin
        acc(8'h02, 8'hB3, w, 1'h1);
        `CK("en", w[0], o_converter_enable)
        `CK("ilim", w[6:4], o_peak_current_limit)
        `CK("byp", w[3:2], {o_forced_switch_close, o_automatic_switch_close})
        acc(8'h02, 8'hB3, 8'h00, 1'h0);
        `CK("mode", {1'h0, w[6:2], 1'h1, w[0]}, o_sfr_rdata)
      end else begin
        acc(8'h00, 8'h96, w, 1'h1);
        `CK("cfg", w[6:0], {o_target_voltage_select, o_local_osc_disable, o_power_switch_size})
        acc(8'h00, 8'h96, 8'h00, 1'h0);
        `CK("cfg", {1'h0, w[6:0]}, o_sfr_rdata)
      end
    end
    acc(8'h02, 8'hB3, 8'h1B, 1'h1);
    @(negedge i_clk);
    `CK("sw", 1'h1, o_switch_close)
    acc(8'h00, 8'h96, 8'h00, 1'h1);
    acc(8'h00, 8'h96, 8'h00, 1'h0);
    `CK("stat", 1'h1, o_sfr_rdata[7])
    acc(8'h02, 8'hB3, 8'h17, 1'h1);
    repeat (3) @(negedge i_clk);
    `CK("sw", 1'h0, o_switch_close)
    i_margin_low = 1'h1;
    repeat (3) @(negedge i_clk);
    `CK("sw", 1'h1, o_switch_close)
    i_margin_low = 1'h0;
    repeat (3) @(negedge i_clk);
    `CK("sw", 1'h1, o_switch_close)
    i_margin_high = 1'h1;
    repeat (3) @(negedge i_clk);
    `CK("sw", 1'h0, o_switch_close)
    acc(8'h00, 8'hB3, 8'h00, 1'h1);
    `CK("en", 1'h1, o_converter_enable)
    acc(8'h01, 8'h96, 8'h00, 1'h0);
    `CK("unmapped", 8'h00, o_sfr_rdata)
    rchk();
    summarize();
  end
endmodule
`default_nettype wire
